// ==== hw/bbx_branch_exec.sv ====
// Executes constant reads, single-bit operations and jumps of the core.
// Assumes program memory answers at most two clocks after the address.
`timescale 1ns/100ps
module bbx_branch_exec
  import bbx_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  code_data,
  input  wire logic        code_external,
  input  wire logic        acc_load_en,
  input  wire logic [7:0]  acc_load_val,
  input  wire logic        data_pointer_load_en,
  input  wire logic [15:0] data_pointer_load_val,
  output logic [15:0]      code_addr,
  output logic             program_store_strobe,
  output logic [7:0]       acc,
  output logic [15:0]      data_pointer,
  output logic [15:0]      pc,
  output logic [7:0]       port_out,
  output logic [7:0]       program_status_word,
  output logic             interrupt_return_done
);
  bbx_state_type st;
  bbx_state_type next_st;
  logic [15:0] next_pc;
  logic [7:0]  op;
  logic [7:0]  next_op;
  logic [7:0]  b1;
  logic [7:0]  next_b1;
  logic [7:0]  b2;
  logic [7:0]  next_b2;
  logic [7:0]  next_acc;
  logic [15:0] next_data_pointer;
  logic [2:0]  sp;
  logic [2:0]  next_sp;
  logic [15:0] ret_stack [STACK_DEPTH];
  logic        push_en;
  logic        next_interrupt_return;
  logic [7:0]  code_s1;
  logic [7:0]  code_byte;
  logic        ext_s1;
  logic        ext_s2;
  logic        slot_en;
  logic [7:0]  opnd;
  logic        bit_val;
  logic        carry;
  logic        bit_wr_en;
  logic [7:0]  bit_wr_addr;
  logic        bit_wr_val;
  logic        carry_wr;
  logic        carry_val;
  logic        bit_wr;
  logic [7:0]  rel;
  logic [15:0] rel_target;
  logic [15:0] table_addr;
  logic [15:0] fetch_addr;
  logic        do_fetch;
  logic [15:0] next_code_addr;
  logic        next_strobe;

  function automatic logic is_page(input logic [7:0] o);
    is_page = (o[4:0] == PAGE_JMP_LOW) || (o[4:0] == PAGE_CALL_LOW);
  endfunction

  function automatic logic is_code_memory_read(input logic [7:0] o);
    is_code_memory_read = (o == OP_CODE_MEMORY_READ_DATA_POINTER) || (o == OP_CODE_MEMORY_READ_PC);
  endfunction

  function automatic logic [1:0] op_len(input logic [7:0] o);
    case (o)
      OP_LONG_ABSOLUTE_JUMP, OP_LCALL, OP_JB, OP_JNB, OP_JBC: op_len = 2'd3;
      OP_SHORT_RELATIVE_JUMP, OP_JC, OP_JNC, OP_ANL_C, OP_ANL_NC, OP_ORL_C, OP_ORL_NC,
      OP_MOV_C_BIT, OP_MOV_BIT_C, OP_CLR_BIT, OP_SET_BIT_OP_BIT, OP_CPL_BIT: op_len = 2'd2;
      default: op_len = is_page(o) ? 2'd2 : 2'd1;
    endcase
  endfunction

  // Opcodes outside this set run over two machine cycles.
  function automatic logic op_single(input logic [7:0] o);
    case (o)
      OP_NOP, OP_CLR_C, OP_SET_BIT_OP_C, OP_CPL_C, OP_CLR_BIT, OP_SET_BIT_OP_BIT, OP_CPL_BIT,
      OP_MOV_C_BIT: op_single = 1'b1;
      default: op_single = 1'b0;
    endcase
  endfunction

  bbx_cycle_timer u_timer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .slot_en (slot_en)
  );

  bbx_bit_space u_bits (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .rd_addr    (opnd),
    .wr_en      (bit_wr_en),
    .wr_addr    (bit_wr_addr),
    .wr_val     (bit_wr_val),
    .acc_parity (^acc),
    .rd_val     (bit_val),
    .carry      (carry),
    .program_status_word        (program_status_word),
    .port_out   (port_out)
  );

  always_comb begin
    opnd       = (st == ST_S1) ? code_byte : b1;
    rel        = (op == OP_JB || op == OP_JNB || op == OP_JBC) ? b2 : b1;
    rel_target = 16'(pc + {{8{rel[7]}}, rel});
    table_addr = 16'(((op == OP_CODE_MEMORY_READ_PC) ? pc : data_pointer) + {8'h00, acc});
    fetch_addr = (st == ST_S2 && is_code_memory_read(op)) ? table_addr : pc;
    case (st)
      ST_S0:   do_fetch = 1'b1;
      ST_S1:   do_fetch = op_len(op) > 2'd1;
      ST_S2:   do_fetch = (op_len(op) == 2'd3) || is_code_memory_read(op);
      default: do_fetch = 1'b0;
    endcase
  end

  always_comb begin
    next_st   = st;
    next_pc   = pc;
    next_op   = op;
    next_b1   = b1;
    next_b2   = b2;
    next_acc  = acc_load_en ? acc_load_val : acc;
    next_data_pointer = data_pointer_load_en ? data_pointer_load_val : data_pointer;
    next_sp   = sp;
    push_en   = 1'b0;
    next_interrupt_return = 1'b0;
    carry_wr  = 1'b0;
    carry_val = 1'b0;
    bit_wr    = 1'b0;
    bit_wr_val = 1'b0;
    next_code_addr = fetch_addr;
    next_strobe = do_fetch && (ext_s2 || fetch_addr >= INT_CODE_LIMIT);
    if (slot_en) begin
      if (do_fetch && !(st == ST_S2 && is_code_memory_read(op))) begin
        next_pc = 16'(pc + 16'h0001);
      end
      case (st)
        ST_S0: begin
          next_op = code_byte;
          next_st = ST_S1;
        end
        ST_S1: begin
          if (op_len(op) > 2'd1) begin
            next_b1 = code_byte;
          end
          next_st = op_single(op) ? ST_S0 : ST_S2;
          case (op)
            OP_CLR_C: carry_wr = 1'b1;
            OP_SET_BIT_OP_C: begin
              carry_wr  = 1'b1;
              carry_val = 1'b1;
            end
            OP_CPL_C: begin
              carry_wr  = 1'b1;
              carry_val = !carry;
            end
            OP_MOV_C_BIT: begin
              carry_wr  = 1'b1;
              carry_val = bit_val;
            end
            OP_CLR_BIT: bit_wr = 1'b1;
            OP_SET_BIT_OP_BIT: begin
              bit_wr     = 1'b1;
              bit_wr_val = 1'b1;
            end
            OP_CPL_BIT: begin
              bit_wr     = 1'b1;
              bit_wr_val = !bit_val;
            end
            default: carry_wr = 1'b0;
          endcase
        end
        ST_S2: begin
          if (op_len(op) == 2'd3) begin
            next_b2 = code_byte;
          end
          if (is_code_memory_read(op)) begin
            next_acc = code_byte;
          end
          next_st = ST_S3;
        end
        ST_S3: begin
          next_st = ST_S0;
          case (op)
            OP_ANL_C: begin
              carry_wr  = 1'b1;
              carry_val = carry & bit_val;
            end
            OP_ANL_NC: begin
              carry_wr  = 1'b1;
              carry_val = carry & !bit_val;
            end
            OP_ORL_C: begin
              carry_wr  = 1'b1;
              carry_val = carry | bit_val;
            end
            OP_ORL_NC: begin
              carry_wr  = 1'b1;
              carry_val = carry | !bit_val;
            end
            OP_MOV_BIT_C: begin
              bit_wr     = 1'b1;
              bit_wr_val = carry;
            end
            OP_SHORT_RELATIVE_JUMP: next_pc = rel_target;
            OP_JC: next_pc = carry ? rel_target : pc;
            OP_JNC: next_pc = carry ? pc : rel_target;
            OP_JB: next_pc = bit_val ? rel_target : pc;
            OP_JNB: next_pc = bit_val ? pc : rel_target;
            OP_JBC: begin
              if (bit_val) begin
                next_pc = rel_target;
                bit_wr  = 1'b1;
              end
            end
            OP_LONG_ABSOLUTE_JUMP: next_pc = {b1, b2};
            OP_LCALL: begin
              push_en = 1'b1;
              next_sp = 3'(sp + 3'h1);
              next_pc = {b1, b2};
            end
            OP_JMP_ADPTR: next_pc = table_addr;
            OP_RET, OP_INTERRUPT_RETURN: begin
              next_sp   = 3'(sp - 3'h1);
              next_pc   = ret_stack[3'(sp - 3'h1)];
              next_interrupt_return = (op == OP_INTERRUPT_RETURN);
            end
            default: begin
              if (op[4:0] == PAGE_CALL_LOW) begin
                push_en = 1'b1;
                next_sp = 3'(sp + 3'h1);
              end
              if (is_page(op)) begin
                next_pc = {pc[15:11], op[7:5], b1};
              end
            end
          endcase
        end
        default: next_st = ST_S0;
      endcase
    end
    bit_wr_en   = carry_wr | bit_wr;
    bit_wr_addr = carry_wr ? CARRY_BIT_ADDR : opnd;
    if (carry_wr) begin
      bit_wr_val = carry_val;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st           <= ST_S0;
      pc           <= PC_RESET;
      op           <= OP_NOP;
      b1           <= 8'h00;
      b2           <= 8'h00;
      acc          <= ACC_RESET;
      data_pointer <= DATA_POINTER_RESET;
      sp           <= 3'h0;
      interrupt_return_done    <= 1'b0;
      code_s1      <= 8'h00;
      code_byte    <= 8'h00;
      ext_s1       <= 1'b0;
      ext_s2       <= 1'b0;
      code_addr    <= PC_RESET;
      program_store_strobe <= 1'b0;
    end else begin
      st           <= next_st;
      pc           <= next_pc;
      op           <= next_op;
      b1           <= next_b1;
      b2           <= next_b2;
      acc          <= next_acc;
      data_pointer <= next_data_pointer;
      sp           <= next_sp;
      interrupt_return_done    <= next_interrupt_return;
      code_s1      <= code_data;
      code_byte    <= code_s1;
      ext_s1       <= code_external;
      ext_s2       <= ext_s1;
      code_addr    <= next_code_addr;
      program_store_strobe <= next_strobe;
    end
  end

  // The return stack is a small private array; overflow wraps and loses the oldest entry.
  always_ff @(posedge sys_clk) begin
    if (push_en) begin
      ret_stack[sp] <= pc;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_rest_of_instr;
    ##6 (slot_en && st == ST_S2) ##6 (slot_en && st == ST_S3) ##6 (slot_en && st == ST_S0);
  endsequence

  a_two_cycle_span: assert property ((slot_en && st == ST_S1 && !op_single(op))
    |-> s_rest_of_instr)
    else $error("Two-cycle instruction did not span two machine cycles.");
  a_one_cycle_op: assert property ((slot_en && st == ST_S1 && op_single(op))
    |=> st == ST_S0 ##5 (slot_en && st == ST_S0))
    else $error("One-cycle instruction did not finish in one machine cycle.");
  a_clr_carry: assert property ((slot_en && st == ST_S1 && op == OP_CLR_C) |=> !carry)
    else $error("Carry clear did not take effect.");
  a_code_memory_read_data_pointer: assert property ((st == ST_S2 && op == OP_CODE_MEMORY_READ_DATA_POINTER && !slot_en)
    |=> code_addr == 16'($past(data_pointer) + {8'h00, $past(acc)}))
    else $error("Pointer-indexed table address is wrong.");
  a_code_memory_read_pc: assert property ((st == ST_S2 && op == OP_CODE_MEMORY_READ_PC && !slot_en)
    |=> code_addr == 16'($past(pc) + {8'h00, $past(acc)}))
    else $error("Counter-indexed table address is wrong.");
  a_strobe_ext: assert property (program_store_strobe
    |-> ($past(ext_s2) || code_addr >= INT_CODE_LIMIT))
    else $error("Program store strobe raised for an internal address.");
  a_rel_jump: assert property ((slot_en && st == ST_S3 && op == OP_SHORT_RELATIVE_JUMP)
    |=> pc == 16'($past(pc) + {{8{$past(rel[7])}}, $past(rel)}))
    else $error("Relative jump target is wrong.");
  a_page_jump: assert property ((slot_en && st == ST_S3 && op[4:0] == PAGE_JMP_LOW)
    |=> pc[15:11] == 5'($past(pc) >> 11) && pc[7:0] == $past(b1))
    else $error("In-page jump changed the upper counter bits.");
  a_long_jump: assert property ((slot_en && st == ST_S3 && op == OP_LONG_ABSOLUTE_JUMP)
    |=> pc == {$past(b1), $past(b2)})
    else $error("Long jump target is wrong.");
  a_jbc_clear: assert property ((slot_en && st == ST_S3 && op == OP_JBC && bit_val && !b1[7])
    |=> !bit_val && pc == $past(rel_target))
    else $error("Test-and-clear jump did not clear and branch.");
  a_interrupt_return_pulse: assert property ((slot_en && st == ST_S3 && op == OP_INTERRUPT_RETURN)
    |=> interrupt_return_done ##1 !interrupt_return_done)
    else $error("Interrupt return did not pulse the done signal once.");
endmodule // bbx_branch_exec

// ==== hw/bbx_pkg.sv ====
// Constants, opcode codes and state type of the bit processor and branch unit.
// Assumes a single clock that also serves as the oscillator of the core.
package bbx_pkg;
  localparam int          OSC_PER_MCYCLE = 12;
  localparam int          OSC_PER_SLOT   = OSC_PER_MCYCLE / 2;
  localparam logic [3:0]  TIMER_LAST     = 4'(OSC_PER_MCYCLE - 1);
  localparam logic [3:0]  SLOT_LAST      = 4'(OSC_PER_SLOT - 1);
  localparam logic [15:0] PC_RESET       = 16'h0000;
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [15:0] DATA_POINTER_RESET     = 16'h0000;
  localparam logic [7:0]  PSW_RESET      = 8'h00;
  localparam logic [7:0]  PORT_RESET     = 8'hFF;
  localparam logic [15:0] INT_CODE_LIMIT = 16'h1000;
  localparam int          STACK_DEPTH    = 8;
  localparam logic [7:0]  SFR_PORT_BASE  = 8'h90;
  localparam logic [7:0]  SFR_PSW_BASE   = 8'hD0;
  localparam logic [2:0]  PSW_CY_POS     = 3'h7;
  localparam logic [2:0]  PSW_P_POS      = 3'h0;
  localparam logic [7:0]  CARRY_BIT_ADDR = {SFR_PSW_BASE[7:3], PSW_CY_POS};
  // Opcode codes.
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_LONG_ABSOLUTE_JUMP      = 8'h02;
  localparam logic [7:0] OP_LCALL     = 8'h12;
  localparam logic [7:0] OP_JBC       = 8'h10;
  localparam logic [7:0] OP_JB        = 8'h20;
  localparam logic [7:0] OP_JNB       = 8'h30;
  localparam logic [7:0] OP_JC        = 8'h40;
  localparam logic [7:0] OP_JNC       = 8'h50;
  localparam logic [7:0] OP_RET       = 8'h22;
  localparam logic [7:0] OP_INTERRUPT_RETURN      = 8'h32;
  localparam logic [7:0] OP_ORL_C     = 8'h72;
  localparam logic [7:0] OP_JMP_ADPTR = 8'h73;
  localparam logic [7:0] OP_SHORT_RELATIVE_JUMP      = 8'h80;
  localparam logic [7:0] OP_ANL_C     = 8'h82;
  localparam logic [7:0] OP_CODE_MEMORY_READ_PC   = 8'h83;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_CODE_MEMORY_READ_DATA_POINTER = 8'h93;
  localparam logic [7:0] OP_ORL_NC    = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam logic [7:0] OP_ANL_NC    = 8'hB0;
  localparam logic [7:0] OP_CPL_BIT   = 8'hB2;
  localparam logic [7:0] OP_CPL_C     = 8'hB3;
  localparam logic [7:0] OP_CLR_BIT   = 8'hC2;
  localparam logic [7:0] OP_CLR_C     = 8'hC3;
  localparam logic [7:0] OP_SET_BIT_OP_BIT  = 8'hD2;
  localparam logic [7:0] OP_SET_BIT_OP_C    = 8'hD3;
  localparam logic [4:0] PAGE_JMP_LOW  = 5'h01;
  localparam logic [4:0] PAGE_CALL_LOW = 5'h11;

  typedef enum logic [3:0] {
    ST_S0 = 4'h1,
    ST_S1 = 4'h2,
    ST_S2 = 4'h4,
    ST_S3 = 4'h8
  } bbx_state_type;
endpackage

// ==== hw/bbx_cycle_timer.sv ====
// Half machine cycle timer: one enable pulse every six clocks.
// Assumes sys_clk is the oscillator, so twelve clocks make a machine cycle.
`timescale 1ns/100ps
module bbx_cycle_timer
  import bbx_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  output logic      slot_en
);
  logic [3:0] count;
  logic [3:0] next_count;

  always_comb begin
    next_count = (count == TIMER_LAST) ? 4'h0 : 4'(count + 4'h1);
    slot_en    = (count == SLOT_LAST) || (count == TIMER_LAST);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 4'h0;
    end else begin
      count <= next_count;
    end
  end

  a_slot_spacing: assert property (@(posedge sys_clk) disable iff (sys_rst)
    slot_en |=> !slot_en [*5] ##1 slot_en)
    else $error("Slot enables are not six clocks apart.");
endmodule // bbx_cycle_timer

// ==== hw/bbx_bit_space.sv ====
// Bit-addressable storage: 128 RAM bits, the port latch and the status word.
// Assumes one write per clock; reads are combinational from the stored bits.
`timescale 1ns/100ps
module bbx_bit_space
  import bbx_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] rd_addr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic       wr_val,
  input  wire logic       acc_parity,
  output logic            rd_val,
  output logic            carry,
  output logic [7:0]      program_status_word,
  output logic [7:0]      port_out
);
  logic [127:0] ram_bits;
  logic [127:0] next_ram_bits;
  logic [7:0]   next_psw;
  logic [7:0]   next_port;

  always_comb begin
    next_ram_bits = ram_bits;
    next_psw      = program_status_word;
    next_port     = port_out;
    if (wr_en) begin
      if (!wr_addr[7]) begin
        next_ram_bits[wr_addr[6:0]] = wr_val;
      end else if ({wr_addr[7:3], 3'h0} == SFR_PORT_BASE) begin
        next_port[wr_addr[2:0]] = wr_val;
      end else if ({wr_addr[7:3], 3'h0} == SFR_PSW_BASE) begin
        next_psw[wr_addr[2:0]] = wr_val;
      end
    end
    // The parity flag always follows the accumulator, so writes to it are lost.
    next_psw[PSW_P_POS] = acc_parity;
    if (!rd_addr[7]) begin
      rd_val = ram_bits[rd_addr[6:0]];
    end else if ({rd_addr[7:3], 3'h0} == SFR_PORT_BASE) begin
      rd_val = port_out[rd_addr[2:0]];
    end else if ({rd_addr[7:3], 3'h0} == SFR_PSW_BASE) begin
      rd_val = program_status_word[rd_addr[2:0]];
    end else begin
      rd_val = 1'b0;
    end
    carry = program_status_word[PSW_CY_POS];
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ram_bits <= '0;
      program_status_word      <= PSW_RESET;
      port_out <= PORT_RESET;
    end else begin
      ram_bits <= next_ram_bits;
      program_status_word      <= next_psw;
      port_out <= next_port;
    end
  end
endmodule // bbx_bit_space

// ==== dv/bbx_code_mem.sv ====
// Behavioural program memory that answers the code fetch port of the branch unit.
// Assumes the bench fills mem through a hierarchical path before it releases reset.
`timescale 1ns/100ps
module bbx_code_mem
  import bbx_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] code_addr,
  input  wire logic        program_store_strobe,
  input  wire logic        code_external,
  input  wire logic        slow,
  output logic [7:0]       code_data
);
  logic [7:0] mem [0:65535];
  logic [7:0] data_q;
  logic [7:0] raw;
  logic [7:0] last;
  logic       released;

  // The memory has no write port, so a table can only ever be read.
  assign released = (code_external || (code_addr >= INT_CODE_LIMIT)) && !program_store_strobe;

  // A slow part answers one clock late; a released bus shows the inverse of its last byte,
  // so a fetch that forgets the strobe cannot pick up a lucky value.
  always_comb begin
    raw = slow ? data_q : mem[code_addr];
    code_data = released ? ~last : raw;
  end

  always_ff @(posedge sys_clk) begin
    data_q <= mem[code_addr];
    if (!released) begin
      last <= raw;
    end
  end
endmodule // bbx_code_mem

// ==== dv/test_boolean_branch_exec.sv ====
// Self-checking bench for the constant read, bit processor and jump unit.
// Assumes bbx_code_mem as program memory; each program ends in a jump to itself.
`timescale 1ns/100ps
module test_boolean_branch_exec
  import bbx_pkg::*;
;
  typedef struct {
    logic [15:0] halt;
    logic [7:0]  acc;
    logic [7:0]  port;
    logic        carry;
    logic        ext;
    logic        interrupt_return;
    logic [15:0] dp;
  } bbx_note_type;
  localparam logic [7:0] JOPS [8] = '{OP_JC, OP_JNC, OP_JB, OP_JNB, OP_JB, OP_JNB, OP_JBC, OP_JBC};
  localparam logic [7:0] JBITS [8] = '{8'h00, 8'h00, 8'h11, 8'h11, 8'h10, 8'h10, 8'h11, 8'h11};
  // Bit i stays set only where jump i is taken and skips the clear of port line i.
  localparam logic [7:0] JTAKEN = 8'h65;

  logic         sys_clk       = 1'b0;
  logic         sys_rst       = 1'b1;
  logic         code_external = 1'b0;
  logic         slow          = 1'b0;
  logic         acc_load_en   = 1'b0;
  logic [7:0]   acc_load_val  = 8'h00;
  logic         data_pointer_load_en  = 1'b0;
  logic [15:0]  data_pointer_load_val = 16'h0000;
  logic [7:0]   code_data;
  logic [15:0]  code_addr;
  logic [15:0]  data_pointer;
  logic [15:0]  pc;
  logic         program_store_strobe;
  logic         interrupt_return_done;
  logic         ext_seen;
  logic         interrupt_return_seen;
  logic [7:0]   acc;
  logic [7:0]   port_out;
  logic [7:0]   program_status_word;
  bbx_note_type notes[$];
  int           failures      = 0;
  int           cmp_count     = 0;
  int           seed          = 17971;

  always #2.5 sys_clk = ~sys_clk;

  bbx_branch_exec u_bbx_branch_exec (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .code_data(code_data),
    .code_external(code_external), .acc_load_en(acc_load_en), .acc_load_val(acc_load_val),
    .data_pointer_load_en(data_pointer_load_en), .data_pointer_load_val(data_pointer_load_val), .code_addr(code_addr),
    .program_store_strobe(program_store_strobe), .acc(acc), .data_pointer(data_pointer),
    .pc(pc), .port_out(port_out), .program_status_word(program_status_word), .interrupt_return_done(interrupt_return_done)
  );

  bbx_code_mem u_bbx_code_mem (
    .sys_clk(sys_clk), .code_addr(code_addr), .program_store_strobe(program_store_strobe),
    .code_external(code_external), .slow(slow), .code_data(code_data)
  );

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ext_seen <= 1'b0;
      interrupt_return_seen <= 1'b0;
    end else begin
      if (program_store_strobe === 1'b1) ext_seen <= 1'b1;
      if (interrupt_return_done === 1'b1) interrupt_return_seen <= 1'b1;
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic until_pc(input logic [15:0] h, input bit want, inout int n);
    int k;
    for (k = 0; k < 400 && ((pc === h) != want); k++) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    if (k == 400) begin
      failures++;
      final_report();
    end
  endtask

  task automatic clear_mem();
    for (int i = 0; i < 65536; i++) u_bbx_code_mem.mem[i] = 8'h00;
  endtask

  task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i]) u_bbx_code_mem.mem[16'(a + i)] = b[i];
  endtask

  task automatic start(input logic ext, input logic slw, input logic [7:0] a,
                       input logic [15:0] dp);
    // Callers return on a clock edge, so step off it before touching any input.
    #1;
    code_external = ext;
    slow = slw;
    sys_rst = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    @(posedge sys_clk);
    #1;
    acc_load_en = 1'b1;
    acc_load_val = a;
    data_pointer_load_en = 1'b1;
    data_pointer_load_val = dp;
    @(posedge sys_clk);
    #1;
    acc_load_en = 1'b0;
    data_pointer_load_en = 1'b0;
  endtask

  task automatic expect_run(input bbx_note_type e);
    int k;
    notes.push_back(e);
    for (k = 0; k < 3000 && notes.size() > 0; k++) @(posedge sys_clk);
    if (k == 3000) begin
      failures++;
      final_report();
    end
  endtask

  // Results are judged only once the program sits in its self loop, so two-cycle
  // writes that land after the counter has moved on are settled by then.
  initial begin : monitor
    int n;
    bbx_note_type e;
    forever begin
      @(posedge sys_clk);
      #2;
      if (notes.size() > 0 && sys_rst === 1'b0 && pc === notes[0].halt) begin
        e = notes[0];
        repeat (48) @(posedge sys_clk);
        #2;
        n = 0;
        until_pc(e.halt, 1'b0, n);
        until_pc(e.halt, 1'b1, n);
        n = 0;
        until_pc(e.halt, 1'b0, n);
        until_pc(e.halt, 1'b1, n);
        check("loop period", 16'(n), 16'h0018);
        check("acc", 16'(acc), 16'(e.acc));
        check("port", 16'(port_out), 16'(e.port));
        check("carry", 16'(program_status_word[PSW_CY_POS]), 16'(e.carry));
        check("parity", 16'(program_status_word[PSW_P_POS]), 16'(^e.acc));
        check("strobe", 16'(ext_seen), 16'(e.ext));
        check("int done", 16'(interrupt_return_seen), 16'(e.interrupt_return));
        check("pointer", data_pointer, e.dp);
        void'(notes.pop_front());
      end
    end
  end

  initial begin : main
    logic [7:0]  a;
    logic [7:0]  v;
    logic [15:0] p;
    a = 8'($random(seed));
    v = 8'($random(seed));
    clear_mem();
    put(16'h0000, {OP_CODE_MEMORY_READ_DATA_POINTER, OP_SHORT_RELATIVE_JUMP, 8'hFE});
    put(16'(16'h2000 + a), {v});
    start(1'b0, 1'b0, a, 16'h2000);
    expect_run('{16'h0001, v, 8'hFF, 1'b0, 1'b1, 1'b0, 16'h2000});
    put(16'h00EF, {~v});
    start(1'b0, 1'b0, 8'hFF, 16'hFFF0);
    expect_run('{16'h0001, ~v, 8'hFF, 1'b0, 1'b0, 1'b0, 16'hFFF0});
    a = 8'($random(seed)) | 8'h04;
    clear_mem();
    put(16'h0000, {OP_CODE_MEMORY_READ_PC, OP_SHORT_RELATIVE_JUMP, 8'hFE});
    put(16'(16'h0001 + a), {v});
    start(1'b0, 1'b0, a, 16'h0000);
    expect_run('{16'h0001, v, 8'hFF, 1'b0, 1'b0, 1'b0, 16'h0000});
    clear_mem();
    put(16'h0000, {8'hC3, 8'h92, 8'h92, 8'hD3, 8'hB0, 8'h92, 8'h82, 8'h91, 8'hC2, 8'h97,
                   8'hB3, 8'h72, 8'h97, 8'hA0, 8'h92, 8'hB2, 8'hD7, 8'h92, 8'h96, 8'hB2,
                   8'h90, 8'hD2, 8'h10, 8'hA2, 8'h10, 8'h80, 8'hFE});
    start(1'b0, 1'b0, 8'h00, 16'h0000);
    expect_run('{16'h0019, 8'h00, 8'h3A, 1'b1, 1'b0, 1'b0, 16'h0000});
    clear_mem();
    put(16'h0000, {8'hD3, 8'hC2, 8'h10, 8'hD2, 8'h11});
    p = 16'h0005;
    for (int i = 0; i < 8; i++) begin
      if (JOPS[i][7:5] == 3'h2) begin
        put(p, {JOPS[i], 8'h02, 8'hC2, 8'(8'h90 + i)});
        p += 16'h0004;
      end else begin
        put(p, {JOPS[i], JBITS[i], 8'h02, 8'hC2, 8'(8'h90 + i)});
        p += 16'h0005;
      end
    end
    put(p, {8'h80, 8'hFE});
    start(1'b0, 1'b0, 8'h00, 16'h0000);
    expect_run('{p, 8'h00, JTAKEN, 1'b1, 1'b0, 1'b0, 16'h0000});
    clear_mem();
    put(16'h0000, {OP_LCALL, 8'h00, 8'h40, OP_LONG_ABSOLUTE_JUMP, 8'h12, 8'h34});
    put(16'h0040, {OP_INTERRUPT_RETURN});
    put(16'h1234, {8'hA1, 8'h67});
    put(16'h1567, {OP_JMP_ADPTR});
    put(16'h1730, {OP_SHORT_RELATIVE_JUMP, 8'h80});
    put(16'h16B2, {OP_SHORT_RELATIVE_JUMP, 8'hFE});
    start(1'b0, 1'b1, 8'h30, 16'h1700);
    expect_run('{16'h16B2, 8'h30, 8'hFF, 1'b0, 1'b1, 1'b1, 16'h1700});
    a = 8'($random(seed));
    clear_mem();
    put(16'h0000, {OP_SHORT_RELATIVE_JUMP, 8'hFE});
    start(1'b1, 1'b1, a, 16'h0000);
    expect_run('{16'h0000, a, 8'hFF, 1'b0, 1'b1, 1'b0, 16'h0000});
    final_report();
  end
endmodule // test_boolean_branch_exec
